// ### core/pllcd_regs.svh
// register offsets, field positions, reset values and constants
// Functional notes
// R1: fractional multiplier low byte is bits 7-0 of the fraction low register.
// R2: software writes fractional multiplier 0 to 9999 only; above is reserved.
// R3: integer multiplier joins one upper bit with the integer low byte.
// R4: integer multiplier code maps to 1..511; code zero is reserved.
// R5: auto clock detection overrides all programmed multipliers and dividers.
// R6: N divider bits 7-5; code zero divides by 8, else by code.
// R7: PDM divider bits 4-2; codes 0..4 give 1,2,4,8,16; 5..7 unused.
// R8: M divider bits 7-2; code zero divides by 64, else by code.
// R9: ADC modulator divider bits 1-0; codes 0..2 give 1,2,4; 3 reserved.
// R10: DAC modulator divider bits 5-4; codes 0..2 give 1,2,4; 3 reserved.
// R11: primary bit-clock divider top bit sits in bit 2 of register 0x3B.
// R12: secondary bit-clock divider top bit sits in bit 1 of register 0x3B.
// R13: software writes reset values into reserved bits.
// R14: fraction upper bits are bits 5-0 of the preceding register; the code takes them from frac_mult_high_i.
// R15: integer upper bit is bit 7 of the preceding register; the code takes it from int_mult_high_i.
// R16: dividers output input clock over ratio; ratio changes without glitch. Ratio one gives half the input clock.
`ifndef PLLCD_REGS_SVH
`define PLLCD_REGS_SVH
// ==========================================================
// register offsets
`define PLLCD_OFS_FRAC_LOW 7'h37
`define PLLCD_OFS_INT_LOW  7'h38
`define PLLCD_OFS_N_PDM    7'h39
`define PLLCD_OFS_M_ADC    7'h3A
`define PLLCD_OFS_DAC_BCK  7'h3B
// ==========================================================
// reset values
`define PLLCD_RST_FRAC_LOW 8'h00
`define PLLCD_RST_INT_LOW  8'h08
`define PLLCD_RST_N_PDM    8'h20
`define PLLCD_RST_M_ADC    8'h04
`define PLLCD_RST_DAC_BCK  8'h00
// ==========================================================
// field positions
`define PLLCD_N_HI   7
`define PLLCD_N_LO   5
`define PLLCD_PDM_HI 4
`define PLLCD_PDM_LO 2
`define PLLCD_M_HI   7
`define PLLCD_M_LO   2
`define PLLCD_ADC_HI 1
`define PLLCD_ADC_LO 0
`define PLLCD_DAC_HI 5
`define PLLCD_DAC_LO 4
`define PLLCD_PBCK_BIT 2
`define PLLCD_SBCK_BIT 1
// writable mask of register 0x3B (bit 0 reads as zero)
`define PLLCD_DAC_BCK_WMASK 8'hFE
// ==========================================================
// auto detection defaults used while detection is on
`define PLLCD_AUTO_N   7'h01
`define PLLCD_AUTO_M   7'h01
`define PLLCD_AUTO_PDM 7'h01
`endif

// ### core/pllcd_pkg.sv
// types shared by the clock configuration block
package pllcd_pkg;
  typedef logic [7:0]  pllcd_byte_type;
  typedef logic [13:0] pllcd_frac_type;
  typedef logic [8:0]  pllcd_int_type;
  typedef logic [6:0]  pllcd_ratio_type;
endpackage

// ### core/pllcd_clkdiv.sv
// glitch-free integer clock divider, ratio taken at period boundary
module pllcd_clkdiv #(
  parameter int W = 7
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] ratio_i,
  output logic              clk_o
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] ratio_r;
  logic         out_r;
  logic [W-1:0] half;
  logic         wrap;
  logic [W-1:0] hold_ratio;

  // ratio only loads at the end of a period, so no runt pulse
  assign hold_ratio = (ratio_r == '0) ? {{(W-1){1'b0}}, 1'b1} : ratio_r;
  assign half = hold_ratio >> 1;
  assign wrap = (cnt_r >= hold_ratio - {{(W-1){1'b0}}, 1'b1});

  // counter and output phase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r   <= '0;
      ratio_r <= {{(W-1){1'b0}}, 1'b1};
      out_r   <= 1'b0;
    end else if (wrap) begin
      cnt_r   <= '0;
      ratio_r <= ratio_i; // R16
      out_r   <= 1'b1;
    end else begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      out_r <= (cnt_r + {{(W-1){1'b0}}, 1'b1}) < half;
    end
  end

  // ratio one: toggle every cycle (half the input clock), otherwise counted phase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_o <= 1'b0;
    end else begin
      clk_o <= (hold_ratio == {{(W-1){1'b0}}, 1'b1}) ? ~clk_o : out_r; // R16
    end
  end
endmodule

// ### core/pllcd_top.sv
// clock configuration registers with decoded divider outputs
`include "pllcd_regs.svh"
module pllcd_top (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [6:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        auto_detect_i,
  input  wire logic [5:0]  frac_mult_high_i,
  input  wire logic        int_mult_high_i,
  output logic      [13:0] frac_mult_o,
  output logic      [8:0]  int_mult_o,
  output logic      [6:0]  n_ratio_o,
  output logic      [6:0]  m_ratio_o,
  output logic      [4:0]  pdm_ratio_o,
  output logic      [2:0]  adc_mod_ratio_o,
  output logic      [2:0]  dac_mod_ratio_o,
  output logic             primary_bitclk_div_top_o,
  output logic             secondary_bitclk_div_top_o,
  output logic             n_clk_o,
  output logic             m_clk_o,
  output logic             pdm_clk_o
);
  // ==========================================================
  // register storage
  pllcd_pkg::pllcd_byte_type frac_low_r, int_low_r, n_pdm_r, m_adc_r;
  pllcd_pkg::pllcd_byte_type dac_bck_r;
  logic auto_s1_r, auto_s2_r, auto_s3_r, auto_r;

  // ==========================================================
  // write strobes
  wire w_frac = reg_wr_i && (reg_addr_i == `PLLCD_OFS_FRAC_LOW);
  wire w_int  = reg_wr_i && (reg_addr_i == `PLLCD_OFS_INT_LOW);
  wire w_npdm = reg_wr_i && (reg_addr_i == `PLLCD_OFS_N_PDM);
  wire w_madc = reg_wr_i && (reg_addr_i == `PLLCD_OFS_M_ADC);
  wire w_dbck = reg_wr_i && (reg_addr_i == `PLLCD_OFS_DAC_BCK);

  // register writes; reserved bits stored as written except 0x3B bit 0
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frac_low_r <= `PLLCD_RST_FRAC_LOW;
      int_low_r  <= `PLLCD_RST_INT_LOW;
      n_pdm_r    <= `PLLCD_RST_N_PDM;
      m_adc_r    <= `PLLCD_RST_M_ADC;
      dac_bck_r  <= `PLLCD_RST_DAC_BCK;
    end else begin
      if (w_frac) frac_low_r <= reg_wdata_i; // R1
      if (w_int)  int_low_r  <= reg_wdata_i; // R3
      if (w_npdm) n_pdm_r    <= reg_wdata_i;
      if (w_madc) m_adc_r    <= reg_wdata_i;
      if (w_dbck) dac_bck_r  <= reg_wdata_i & `PLLCD_DAC_BCK_WMASK;
    end
  end

  // ==========================================================
  // read mux, registered
  wire [7:0] rd_nxt =
    (reg_addr_i == `PLLCD_OFS_FRAC_LOW) ? frac_low_r :
    (reg_addr_i == `PLLCD_OFS_INT_LOW)  ? int_low_r  :
    (reg_addr_i == `PLLCD_OFS_N_PDM)    ? n_pdm_r    :
    (reg_addr_i == `PLLCD_OFS_M_ADC)    ? m_adc_r    :
    (reg_addr_i == `PLLCD_OFS_DAC_BCK)  ? dac_bck_r  : 8'h00;

  // auto detect pin through three flops, changes when last two agree
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      auto_s1_r <= 1'b0;
      auto_s2_r <= 1'b0;
      auto_s3_r <= 1'b0;
      auto_r    <= 1'b0;
    end else begin
      auto_s1_r <= auto_detect_i;
      auto_s2_r <= auto_s1_r;
      auto_s3_r <= auto_s2_r;
      if (auto_s2_r == auto_s3_r) auto_r <= auto_s3_r;
    end
  end

  // ==========================================================
  // field decode
  wire [2:0] n_code   = n_pdm_r[`PLLCD_N_HI:`PLLCD_N_LO];
  wire [2:0] pdm_code = n_pdm_r[`PLLCD_PDM_HI:`PLLCD_PDM_LO];
  wire [5:0] m_code   = m_adc_r[`PLLCD_M_HI:`PLLCD_M_LO];
  wire [1:0] adc_code = m_adc_r[`PLLCD_ADC_HI:`PLLCD_ADC_LO];
  wire [1:0] dac_code = dac_bck_r[`PLLCD_DAC_HI:`PLLCD_DAC_LO];

  wire [6:0] n_dec = (n_code == 3'h0) ? 7'h08 : {4'h0, n_code}; // R6
  wire [6:0] m_dec = (m_code == 6'h00) ? 7'h40 : {1'b0, m_code}; // R8
  wire [4:0] pdm_dec = (pdm_code > 3'h4) ? 5'h01 :
                       5'(5'h01 << pdm_code); // R7
  wire [2:0] adc_dec = (adc_code == 2'h3) ? 3'h1 :
                       3'(3'h1 << adc_code); // R9
  wire [2:0] dac_dec = (dac_code == 2'h3) ? 3'h1 :
                       3'(3'h1 << dac_code); // R10
  wire [13:0] frac_dec = {frac_mult_high_i, frac_low_r}; // R1 R14
  wire [8:0] int_dec = {int_mult_high_i, int_low_r}; // R3 R15 R4

  // auto detection replaces programmed settings
  wire [6:0] n_sel   = auto_r ? `PLLCD_AUTO_N : n_dec; // R5
  wire [6:0] m_sel   = auto_r ? `PLLCD_AUTO_M : m_dec; // R5
  wire [6:0] pdm_sel = auto_r ? `PLLCD_AUTO_PDM : {2'b00, pdm_dec}; // R5

  // registered decoded outputs
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o                <= 8'h00;
      frac_mult_o                <= 14'h0000;
      int_mult_o                 <= 9'h000;
      n_ratio_o                  <= 7'h00;
      m_ratio_o                  <= 7'h00;
      pdm_ratio_o                <= 5'h00;
      adc_mod_ratio_o            <= 3'h0;
      dac_mod_ratio_o            <= 3'h0;
      primary_bitclk_div_top_o   <= 1'b0;
      secondary_bitclk_div_top_o <= 1'b0;
    end else begin
      reg_rdata_o     <= rd_nxt;
      frac_mult_o     <= auto_r ? 14'h0000 : frac_dec; // R5
      int_mult_o      <= auto_r ? 9'h000 : int_dec; // R5
      n_ratio_o       <= n_sel;
      m_ratio_o       <= m_sel;
      pdm_ratio_o     <= pdm_sel[4:0];
      adc_mod_ratio_o <= auto_r ? 3'h1 : adc_dec; // R5
      dac_mod_ratio_o <= auto_r ? 3'h1 : dac_dec; // R5
      primary_bitclk_div_top_o   <= ~auto_r &
                                    dac_bck_r[`PLLCD_PBCK_BIT]; // R11
      secondary_bitclk_div_top_o <= ~auto_r &
                                    dac_bck_r[`PLLCD_SBCK_BIT]; // R12
    end
  end

  // ==========================================================
  // divided clocks
  pllcd_clkdiv #(.W(7)) u_n_divider (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .ratio_i (n_sel),
    .clk_o   (n_clk_o)
  );
  pllcd_clkdiv #(.W(7)) u_m_divider (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .ratio_i (m_sel),
    .clk_o   (m_clk_o)
  );
  pllcd_clkdiv #(.W(7)) u_pdiv (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .ratio_i (pdm_sel),
    .clk_o   (pdm_clk_o)
  );

  // ==========================================================
  // checks
  property p_n_zero;
    @(posedge clk_i) disable iff (!rstn_i)
      (!auto_r && n_code == 3'h0) |=> (n_ratio_o == 7'h08);
  endproperty
  a_n_zero: assert property (p_n_zero) else $error("n code 0 not 8"); // R6

  property p_m_zero;
    @(posedge clk_i) disable iff (!rstn_i)
      (!auto_r && m_code == 6'h00) |=> (m_ratio_o == 7'h40);
  endproperty
  a_m_zero: assert property (p_m_zero) else $error("m code 0 not 64"); // R8

  property p_pdm;
    @(posedge clk_i) disable iff (!rstn_i)
      (!auto_r && pdm_code == 3'h4) |=> (pdm_ratio_o == 5'h10);
  endproperty
  a_pdm: assert property (p_pdm) else $error("pdm code 4 not 16"); // R7

  property p_adc;
    @(posedge clk_i) disable iff (!rstn_i)
      (!auto_r && adc_code == 2'h2) |=> (adc_mod_ratio_o == 3'h4);
  endproperty
  a_adc: assert property (p_adc) else $error("adc code 2 not 4"); // R9

  property p_dac;
    @(posedge clk_i) disable iff (!rstn_i)
      (!auto_r && dac_code == 2'h1) |=> (dac_mod_ratio_o == 3'h2);
  endproperty
  a_dac: assert property (p_dac) else $error("dac code 1 not 2"); // R10

  property p_frac;
    @(posedge clk_i) disable iff (!rstn_i)
      w_frac && !auto_r ##1 !auto_r
        |=> (frac_mult_o[7:0] == $past(reg_wdata_i, 2));
  endproperty
  a_frac: assert property (p_frac) else $error("fraction low lost"); // R1

  property p_int;
    @(posedge clk_i) disable iff (!rstn_i)
      !auto_r |=> (int_mult_o[8] == $past(int_mult_high_i));
  endproperty
  a_int: assert property (p_int) else $error("integer top wrong"); // R15

  property p_auto;
    @(posedge clk_i) disable iff (!rstn_i)
      auto_r |=> (frac_mult_o == 14'h0000 && !primary_bitclk_div_top_o);
  endproperty
  a_auto: assert property (p_auto) else $error("auto not honoured"); // R5

  property p_bck;
    @(posedge clk_i) disable iff (!rstn_i)
      w_dbck && !auto_r ##1 !auto_r |=>
        (secondary_bitclk_div_top_o == $past(reg_wdata_i[1], 2));
  endproperty
  a_bck: assert property (p_bck) else $error("bitclk top wrong"); // R12

  property p_pbck;
    @(posedge clk_i) disable iff (!rstn_i)
      w_dbck && !auto_r ##1 !auto_r |=>
        (primary_bitclk_div_top_o == $past(reg_wdata_i[2], 2));
  endproperty
  a_pbck: assert property (p_pbck) else $error("primary top wrong"); // R11

  property p_n_code;
    @(posedge clk_i) disable iff (!rstn_i)
      (!auto_r && n_code != 3'h0) |=>
        (n_ratio_o == {4'h0, $past(n_code)});
  endproperty
  a_n_code: assert property (p_n_code) else $error("n code not ratio"); // R6

  property p_m_code;
    @(posedge clk_i) disable iff (!rstn_i)
      (!auto_r && m_code != 6'h00) |=>
        (m_ratio_o == {1'b0, $past(m_code)});
  endproperty
  a_m_code: assert property (p_m_code) else $error("m code not ratio"); // R8

  property p_auto_div;
    @(posedge clk_i) disable iff (!rstn_i)
      auto_r |=> (n_ratio_o == 7'h01 && m_ratio_o == 7'h01 &&
                  pdm_ratio_o == 5'h01 && dac_mod_ratio_o == 3'h1);
  endproperty
  a_auto_div: assert property (p_auto_div) else $error("auto div wrong"); // R5
endmodule

// ### verif/test_pllcd_top.sv
// self-checking testbench for the clock configuration block
`include "pllcd_regs.svh"
module test_pllcd_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // stimulus, outputs and bench-side register model
  logic        clk_i;
  logic        rstn_i;
  logic [6:0]  reg_addr_i;
  logic        reg_wr_i;
  logic [7:0]  reg_wdata_i;
  logic        auto_detect_i;
  logic [5:0]  frac_mult_high_i;
  logic        int_mult_high_i;
  wire  [7:0]  rd;
  wire  [13:0] fr;
  wire  [8:0]  im;
  wire  [6:0]  nr;
  wire  [6:0]  mr;
  wire  [4:0]  pr;
  wire  [2:0]  ar;
  wire  [2:0]  dr;
  wire         pt;
  wire         st;
  wire  [2:0]  dclk;
  logic [2:0]  dclk_d;
  int          per_q [$];
  int          per_seen;
  logic        pdone;
  logic [7:0]  rg [5];
  logic [57:0] exp_q [$];
  logic        look;
  integer      seed;
  integer      error_cnt;
  integer      total_checks;

  pllcd_top u_pllcd_top (
    .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rd),
    .auto_detect_i(auto_detect_i), .frac_mult_high_i(frac_mult_high_i),
    .int_mult_high_i(int_mult_high_i), .frac_mult_o(fr), .int_mult_o(im),
    .n_ratio_o(nr), .m_ratio_o(mr), .pdm_ratio_o(pr),
    .adc_mod_ratio_o(ar), .dac_mod_ratio_o(dr),
    .primary_bitclk_div_top_o(pt), .secondary_bitclk_div_top_o(st),
    .n_clk_o(dclk[0]), .m_clk_o(dclk[1]), .pdm_clk_o(dclk[2]));

  // divided clocks one falling edge back, for rise detection
  always @(negedge clk_i) dclk_d <= dclk;

  // ==========================================================
  // clock, expected-state model and comparison
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  function automatic logic [57:0] expv(input logic [6:0] a);
    logic [7:0] r;
    logic [13:0] f;
    logic [8:0] j;
    logic [6:0] n, m;
    logic [4:0] p;
    logic [2:0] ad, da;
    logic [1:0] bt;
    r = (a >= 7'h37 && a <= 7'h3B) ? rg[a - 7'h37] : 8'h00;
    f = {frac_mult_high_i, rg[0]};
    j = {int_mult_high_i, rg[1]};
    n = (rg[2][7:5] == 3'h0) ? 7'h08 : {4'h0, rg[2][7:5]};
    m = (rg[3][7:2] == 6'h00) ? 7'h40 : {1'b0, rg[3][7:2]};
    p = (rg[2][4:2] < 3'h5) ? 5'h01 << rg[2][4:2] : 5'h01;
    ad = (rg[3][1:0] < 2'h3) ? 3'h1 << rg[3][1:0] : 3'h1;
    da = (rg[4][5:4] < 2'h3) ? 3'h1 << rg[4][5:4] : 3'h1;
    bt = rg[4][2:1];
    if (auto_detect_i) begin
      f = 14'h0000; j = 9'h000; n = 7'h01; m = 7'h01;
      p = 5'h01; ad = 3'h1; da = 3'h1; bt = 2'h0;
    end
    return {r, f, j, n, m, p, ad, da, bt};
  endfunction

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h expected=%h", $time, s, e);
    end
  endtask

  // monitor: takes the oldest note when a result is flagged
  always @(negedge clk_i) begin
    logic [57:0] e;
    if (look && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check({8'h00, rd}, {8'h00, e[57:50]});
      check({2'h0, fr}, {2'h0, e[49:36]});
      check({7'h00, im}, {7'h00, e[35:27]});
      check({9'h000, nr}, {9'h000, e[26:20]});
      check({9'h000, mr}, {9'h000, e[19:13]});
      check({11'h000, pr}, {11'h000, e[12:8]});
      check({13'h0000, ar}, {13'h0000, e[7:5]});
      check({13'h0000, dr}, {13'h0000, e[4:2]});
      check({15'h0000, pt}, {15'h0000, e[1]});
      check({15'h0000, st}, {15'h0000, e[0]});
    end
    if (pdone && per_q.size() > 0)
      check(16'(per_seen), 16'(per_q.pop_front()));
  end

  // ==========================================================
  // driver tasks, all changes at the falling edge
  task automatic do_reset();
    @(negedge clk_i);
    rstn_i = 1'b0;
    reg_wr_i = 1'b0;
    repeat (12) @(negedge clk_i);
    rg = '{8'h00, 8'h08, 8'h20, 8'h04, 8'h00};
    rstn_i = 1'b1;
  endtask

  // shape written data so the software-side rules hold
  function automatic logic [7:0] legal(input logic [6:0] a,
                                       input logic [7:0] d);
    case (a)
      `PLLCD_OFS_INT_LOW: return (d == 8'h00) ? 8'h01 : d;
      `PLLCD_OFS_N_PDM:
        return {d[7:5], 3'(d[4:2] % 5), 2'h0};
      `PLLCD_OFS_M_ADC: return {d[7:2], 2'(d[1:0] % 3)};
      `PLLCD_OFS_DAC_BCK:
        return {2'h0, 2'(d[5:4] % 3), 1'b0, d[2:1], 1'b0};
      default: return d;
    endcase
  endfunction

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = legal(a, d);
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = v;
    if (a >= 7'h37 && a <= 7'h3B)
      rg[a - 7'h37] = (a == 7'h3B) ? v & `PLLCD_DAC_BCK_WMASK : v;
  endtask

  task automatic obs(input logic [6:0] a);
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    reg_addr_i = a;
    repeat (2) @(negedge clk_i);
    exp_q.push_back(expv(a));
    look <= 1'b1;
    @(negedge clk_i);
    look <= 1'b0;
  endtask

  // measure one period of a divided clock in input clock cycles
  task automatic period(input int k, input int e);
    int n;
    n = 0;
    @(negedge clk_i);
    while (!(dclk[k] && !dclk_d[k])) @(negedge clk_i);
    @(negedge clk_i);
    n = 1;
    while (!(dclk[k] && !dclk_d[k])) begin
      @(negedge clk_i);
      n++;
    end
    per_q.push_back(e);
    per_seen <= n;
    pdone <= 1'b1;
    @(negedge clk_i);
    pdone <= 1'b0;
  endtask

  // let old ratios run out, then measure all three divided clocks
  task automatic clk_test(input int en, input int em, input int ep);
    obs(`PLLCD_OFS_N_PDM);
    repeat (140) @(negedge clk_i);
    period(0, en);
    period(1, em);
    period(2, ep);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rstn_i = 1'b0; reg_addr_i = 7'h37; reg_wr_i = 1'b0; pdone = 1'b0;
    reg_wdata_i = 8'h00; auto_detect_i = 1'b0; frac_mult_high_i = 6'h00;
    int_mult_high_i = 1'b0; look = 1'b0; seed = 61;
    error_cnt = 0; total_checks = 0;
    do_reset();
    for (int a = 'h36; a <= 'h3C; a++) obs(7'(a));
    $display("reset values done");
    for (int c = 0; c < 8; c++) begin
      wr(`PLLCD_OFS_N_PDM, {3'(c), 3'(c), 2'h2});
      wr(`PLLCD_OFS_M_ADC, {3'(c), 3'(c), 2'(c)});
      wr(`PLLCD_OFS_DAC_BCK, {4{2'(c)}});
      obs(7'h39 + 7'(c % 3));
    end
    $display("code sweep done");
    for (int i = 0; i < 40; i++) begin
      frac_mult_high_i = 6'($unsigned($random(seed)) % 39);
      int_mult_high_i = 1'($random(seed));
      wr(7'h36 + 7'($unsigned($random(seed)) % 7), 8'($random(seed)));
      wr(7'h36 + 7'($unsigned($random(seed)) % 7), 8'($random(seed)));
      obs(7'h36 + 7'($unsigned($random(seed)) % 7));
    end
    $display("random traffic done");
    auto_detect_i = 1'b1;
    wr(`PLLCD_OFS_N_PDM, 8'h4C);
    repeat (6) @(negedge clk_i);
    obs(`PLLCD_OFS_N_PDM);
    auto_detect_i = 1'b0;
    repeat (6) @(negedge clk_i);
    obs(`PLLCD_OFS_M_ADC);
    $display("auto detection done");
    wr(`PLLCD_OFS_N_PDM, 8'h68);
    wr(`PLLCD_OFS_M_ADC, 8'h14);
    clk_test(3, 5, 4);
    wr(`PLLCD_OFS_N_PDM, 8'h10);
    wr(`PLLCD_OFS_M_ADC, 8'h00);
    clk_test(8, 64, 16);
    $display("divided clocks done");
    wr(`PLLCD_OFS_INT_LOW, 8'hFF);
    do_reset();
    obs(`PLLCD_OFS_INT_LOW);
    obs(`PLLCD_OFS_N_PDM);
    $display("second reset done");
    print_verdict();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    print_verdict();
  end
endmodule
